// ---- core/bus488_pkg.sv ----
// Purpose: Shared constants and carrier types for the instrument-bus controller.
// Assumes: All bus lines ground-true; open-collector wiring resolved outside.
// Notes:   Pin groups travel as packed structs; enables are low while driving.
package bus488_pkg;

    // =====================================================================
    // Bus geometry
    // =====================================================================
    localparam int DATA_W     = 8;   // Data lines
    localparam int HSK_LINES  = 3;   // Handshake lines
    localparam int MGMT_LINES = 5;   // Management lines
    localparam int CMD_W      = 7;   // Command characters are seven bits

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLK_PERIOD_NS = 8;    // mclk period
    localparam int SETTLE_NS     = 500;  // Data settle before valid is asserted
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IFC_NS        = 100000; // Interface-clear pulse width
    localparam int IFC_CYC       = IFC_NS / CLK_PERIOD_NS;
    localparam int SYNC_STAGES   = 2;

    // =====================================================================
    // Carriers
    // =====================================================================
    // Handshake and management levels, true = asserted (already inverted)
    typedef struct packed {
        logic dav;
        logic nrfd;
        logic ndac;
        logic atn;
        logic ifc;
        logic ren;
        logic eoi;
        logic srq;
    } lines_t;

    // Pin input sample as seen on wires (low = asserted)
    typedef struct packed {
        logic [DATA_W-1:0] data_n;
        lines_t            ctl_n;
    } pins_t;

    // Controller states
    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_WAITRF = 7'h02,
        ST_SETTLE = 7'h04,
        ST_WAITAC = 7'h08,
        ST_LREADY = 7'h10,
        ST_LHOLD  = 7'h20,
        ST_LWAITD = 7'h40
    } state_t;

endpackage

// ---- core/line_sync.sv ----
// Purpose: Two-flop synchroniser for a vector of bus lines.
// Assumes: Asynchronous bus inputs, single local clock.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module line_sync
    import bus488_pkg::*;
#(
    parameter int W = 16
)
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    // Lines
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_st_t;

    sync_st_t st_r;    // Registered state
    sync_st_t st_nxt;  // Next state

    // =====================================================================
    // Stages
    // =====================================================================
    // Idle bus floats high, so reset to all ones
    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = d_in;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
            st_r <= '{s1: '1, s2: '1};
        else
            st_r <= st_nxt;
    end

    assign q_out = st_r.s2;
endmodule

// ---- core/pulse_timer.sv ----
// Purpose: Loadable down counter signalling when a delay has elapsed.
// Assumes: Start pulse reloads; done is a level while count is zero and start is low.
// Notes:   Used for data settling and interface-clear width.
`timescale 1ns/1ps
module pulse_timer
    import bus488_pkg::*;
#(
    parameter int W = 17
)
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    // Control
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } tmr_st_t;

    tmr_st_t st_r;    // Registered count
    tmr_st_t st_nxt;  // Next count

    // =====================================================================
    // Counter
    // =====================================================================
    always_comb
    begin
        st_nxt = st_r;
        if (start)
            st_nxt.cnt = load;
        else if (st_r.cnt != '0)
            st_nxt.cnt = st_r.cnt - 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign done = (st_r.cnt == '0) && !start;
endmodule

// ---- core/bus488_ctrl.sv ----
// Purpose: Host-side system controller, talker and listener for an 8-bit
//          ground-true instrument bus with three-wire handshake.
// Assumes: Outputs are open-collector: an enable low pulls the pin low.
// Notes:   User side is a byte stream with valid/ready; no registers.
`timescale 1ns/1ps

// Overview of operation
// - All lines ground-true, low means asserted
// - Handshake lines wired-OR, high when all release
// - Sixteen lines: eight data, three handshake, five management
// - Cycle starts valid released, listeners hold both
// - Ready listener releases not-ready-for-data
// - Talker waits ready, drives byte, asserts valid
// - Listener asserts not-ready on valid before capture
// - Listener releases not-accepted after capture
// - Talker releases valid and data together
// - Valid false, listeners reassert not-accepted
// - Nobody talks or listens until authorized
// - One system controller, active at power-up
// - Interface clear returns control to system controller
// - Control may pass on and back
// - Attention asserted means data lines carry commands
// - Interface clear aborts all bus activity
// - Commands are seven-bit characters
// - Talker marks final data byte with end line
// - Service request held until satisfied or cleared
// - Listener with remote enable goes remote
module bus488_ctrl
    import bus488_pkg::*;
#(
    parameter int IFC_CYCLES = IFC_CYC,    // Interface-clear width in cycles
    parameter bit SYS_CTRL   = 1'b1        // Strap: this end is system controller
)
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rstn,
    // Bus pins: wire level in, open-drain enables out (low = pull low)
    input  wire pins_t             pin_in,
    output logic [DATA_W-1:0]      data_oe_n,
    output lines_t                 ctl_oe_n,
    // User transmit stream
    input  wire logic              tx_valid,
    input  wire logic [DATA_W-1:0] tx_byte,
    input  wire logic              tx_cmd,     // Send with attention (command)
    input  wire logic              tx_last,    // Mark data byte with end line
    output logic                   tx_ready,
    // User receive stream
    output logic                   rx_valid,
    output logic [DATA_W-1:0]      rx_byte,
    output logic                   rx_end,
    output logic                   rx_cmd,
    input  wire logic              rx_ready,
    // Role control
    input  wire logic              talk_en,    // Authorized to talk
    input  wire logic              listen_en,  // Authorized to listen
    input  wire logic              ifc_req,    // Pulse: issue interface clear
    input  wire logic              ren_set,    // Level: drive remote enable while active controller
    input  wire logic              pass_ctl,   // Pulse: give up active control while in ST_IDLE
    input  wire logic              take_ctl,   // Pulse: control passed to us
    input  wire logic              srq_req,    // Level: request service
    // Status
    output logic                   active_ctl,
    output logic                   srq_seen,
    output logic                   remote,
    output logic                   ifc_busy
);
    // Checks below all sample on mclk and sleep in reset
    default clocking chk_cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        state_t            st;
        logic [DATA_W-1:0] dout;     // Byte driven on data lines
        logic              drv_data; // Data lines driven
        logic              dav;      // Valid asserted
        logic              nrfd;     // Not-ready asserted
        logic              ndac;     // Not-accepted asserted
        logic              atn;
        logic              eoi;
        logic              ifc;
        logic              ren;
        logic              srq;
        logic              ac;       // Active controller
        logic              rxv;
        logic [DATA_W-1:0] rxb;
        logic              rxe;
        logic              rxc;
        logic              rmt;
    } ctl_st_t;

    ctl_st_t st_r;    // Registered state
    ctl_st_t st_nxt;  // Next state

    // Synchronised bus view, wire level
    logic [DATA_W+8-1:0] sync_q;
    logic [DATA_W-1:0]   bus_data;  // True-level data
    lines_t              bus;       // True-level lines

    logic tmr_start;                // Reload timer
    logic [16:0] tmr_load;          // Reload value
    logic tmr_done;                 // Delay elapsed

    // Every bus input synchronised before use
    line_sync #(.W(DATA_W + 8)) u_sync (
        .mclk  (mclk),
        .rstn  (rstn),
        .d_in  (pin_in),
        .q_out (sync_q)
    );

    // Invert to true level: low wire = asserted
    assign bus_data = ~sync_q[DATA_W+8-1:8];
    assign bus      = ~sync_q[7:0];

    pulse_timer #(.W(17)) u_tmr (
        .mclk  (mclk),
        .rstn  (rstn),
        .start (tmr_start),
        .load  (tmr_load),
        .done  (tmr_done)
    );

    // =====================================================================
    // Next-state logic
    // =====================================================================
    always_comb
    begin
        st_nxt    = st_r;
        tmr_start = 1'b0;
        tmr_load  = 17'(SETTLE_CYC);
        st_nxt.ren = st_r.ac && ren_set;
        st_nxt.srq = srq_req && !bus.ifc;
        // Control handover both ways
        if (pass_ctl && st_r.ac && st_r.st == ST_IDLE)
            st_nxt.ac = 1'b0;
        else if (take_ctl)
            st_nxt.ac = 1'b1;
        // Remote mode when addressed to listen with remote enable
        if (bus.ifc)
            st_nxt.rmt = 1'b0;
        else if (listen_en && bus.ren)
            st_nxt.rmt = 1'b1;
        else if (!bus.ren)
            st_nxt.rmt = 1'b0;
        // Receive byte taken by user
        if (st_r.rxv && rx_ready)
            st_nxt.rxv = 1'b0;

        // Interface clear: only system controller drives it
        if (SYS_CTRL && ifc_req && !st_r.ifc)
        begin
            st_nxt.ifc = 1'b1;
            tmr_start  = 1'b1;
            tmr_load   = 17'(IFC_CYCLES);
        end
        else if (st_r.ifc && tmr_done)
            st_nxt.ifc = 1'b0;

        if (st_r.ifc || bus.ifc)
        begin
            // Abort everything, back to starting levels
            st_nxt.st       = ST_IDLE;
            st_nxt.dav      = 1'b0;
            st_nxt.drv_data = 1'b0;
            st_nxt.nrfd     = 1'b0;
            st_nxt.ndac     = 1'b0;
            st_nxt.atn      = 1'b0;
            st_nxt.eoi      = 1'b0;
            st_nxt.ac       = SYS_CTRL;
        end
        else
        begin
            case (st_r.st)
                ST_IDLE:
                begin
                    st_nxt.dav      = 1'b0;
                    st_nxt.drv_data = 1'b0;
                    st_nxt.nrfd     = 1'b0;
                    st_nxt.ndac     = 1'b0;
                    // Talk only if authorized; never listen meanwhile
                    if (tx_valid && ((tx_cmd && st_r.ac) || (!tx_cmd && talk_en)))
                    begin
                        st_nxt.atn = tx_cmd;
                        st_nxt.st  = ST_WAITRF;
                    end
                    else if (listen_en && !talk_en)
                    begin
                        // Listener starts holding both lines
                        st_nxt.nrfd = 1'b1;
                        st_nxt.ndac = 1'b1;
                        st_nxt.st   = ST_LREADY;
                    end
                end
                ST_WAITRF:
                begin
                    // Wait until every listener released not-ready
                    if (!bus.nrfd && !bus.dav)
                    begin
                        st_nxt.dout     = tx_cmd ? {1'b0, tx_byte[CMD_W-1:0]} : tx_byte;
                        st_nxt.eoi      = tx_last && !tx_cmd;
                        st_nxt.drv_data = 1'b1;
                        tmr_start       = 1'b1;
                        st_nxt.st       = ST_SETTLE;
                    end
                end
                ST_SETTLE:
                begin
                    // Byte settled; assert valid after data
                    if (tmr_done)
                    begin
                        st_nxt.dav = 1'b1;
                        st_nxt.st  = ST_WAITAC;
                    end
                end
                ST_WAITAC:
                begin
                    // Accepted by all: drop valid and data together
                    if (!bus.ndac)
                    begin
                        st_nxt.dav      = 1'b0;
                        st_nxt.drv_data = 1'b0;
                        st_nxt.eoi      = 1'b0;
                        st_nxt.atn      = 1'b0;
                        st_nxt.st       = ST_IDLE;
                    end
                end
                ST_LREADY:
                begin
                    // Release not-ready once room for a byte
                    if (!listen_en)
                        st_nxt.st = ST_IDLE;
                    else if (!st_r.rxv)
                        st_nxt.nrfd = 1'b0;
                    if (bus.dav && !st_r.nrfd)
                    begin
                        st_nxt.nrfd = 1'b1;
                        st_nxt.st   = ST_LHOLD;
                    end
                end
                ST_LHOLD:
                begin
                    // Capture, then release not-accepted
                    st_nxt.rxv  = 1'b1;
                    st_nxt.rxb  = bus_data;
                    st_nxt.rxe  = bus.eoi && !bus.atn;
                    st_nxt.rxc  = bus.atn;
                    st_nxt.ndac = 1'b0;
                    st_nxt.st   = ST_LWAITD;
                end
                ST_LWAITD:
                begin
                    // Valid gone: reassert not-accepted
                    if (!bus.dav)
                    begin
                        st_nxt.ndac = 1'b1;
                        st_nxt.st   = ST_LREADY;
                    end
                end
                default:
                    st_nxt.st = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            st_r    <= '0;
            st_r.st <= ST_IDLE;
            st_r.ac <= SYS_CTRL;
        end
        else
            st_r <= st_nxt;
    end

    // =====================================================================
    // Outputs: open-drain enables, low pulls the line low
    // =====================================================================
    assign data_oe_n     = st_r.drv_data ? ~st_r.dout : '1;
    assign ctl_oe_n.dav  = ~st_r.dav;
    assign ctl_oe_n.nrfd = ~st_r.nrfd;
    assign ctl_oe_n.ndac = ~st_r.ndac;
    assign ctl_oe_n.atn  = ~st_r.atn;
    assign ctl_oe_n.ifc  = ~st_r.ifc;
    assign ctl_oe_n.ren  = ~st_r.ren;
    assign ctl_oe_n.eoi  = ~st_r.eoi;
    assign ctl_oe_n.srq  = ~st_r.srq;

    assign tx_ready   = (st_r.st == ST_WAITAC) && !bus.ndac && !st_r.ifc && !bus.ifc;
    assign rx_valid   = st_r.rxv;
    assign rx_byte    = st_r.rxb;
    assign rx_end     = st_r.rxe;
    assign rx_cmd     = st_r.rxc;
    assign active_ctl = st_r.ac;
    assign srq_seen   = bus.srq;
    assign remote     = st_r.rmt;
    assign ifc_busy   = st_r.ifc;

    // =====================================================================
    // Checks
    // =====================================================================
    sequence s_accepted;
        st_r.st == ST_WAITAC && !bus.ndac && !st_r.ifc && !bus.ifc;
    endsequence

    valid_needs_data_a: assert property (st_r.dav |-> st_r.drv_data)
        else $error("valid asserted without data");
    release_together_a: assert property (s_accepted |=> !st_r.dav && !st_r.drv_data)
        else $error("valid and data not released together");
    settle_first_a: assert property ($rose(st_r.drv_data) |=> !st_r.dav)
        else $error("valid asserted with data");
    listen_hold_a: assert property (st_r.st == ST_LHOLD |-> st_r.nrfd)
        else $error("capturing without not-ready asserted");
    ndac_release_a: assert property (
        (st_r.st == ST_LHOLD && !bus.ifc && !st_r.ifc) |=> !st_r.ndac && st_r.rxv)
        else $error("not-accepted not released after capture");
    ndac_reassert_a: assert property (
        (st_r.st == ST_LWAITD && !bus.dav && !bus.ifc && !st_r.ifc) |=> st_r.ndac)
        else $error("not-accepted not reasserted");
    ifc_abort_a: assert property (
        bus.ifc |=> !st_r.dav && !st_r.drv_data && st_r.st == ST_IDLE)
        else $error("interface clear did not abort");
    ifc_regain_a: assert property ((bus.ifc && SYS_CTRL) |=> st_r.ac)
        else $error("system controller did not regain control");
    no_talk_listen_a: assert property (!(st_r.dav && st_r.ndac))
        else $error("talking and listening at once");
    eoi_data_only_a: assert property (st_r.eoi |-> !st_r.atn)
        else $error("end line with attention");
endmodule

// ---- verification/instr_model.sv ----
// Purpose: Behavioural instrument on the far side of the bus.
// Assumes: Open-collector lines; the bench resolves pull-ups.
// Notes:   One byte per talk request; lat sets answer speed.
`timescale 1ns/1ps
module instr_model
    import bus488_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // Bench control
    input  wire logic [1:0] mode,    // 0 idle, 1 listen, 2 talk
    input  wire logic [3:0] lat,     // Answer delay in cycles
    input  wire logic [7:0] tb_byte,
    input  wire logic       tb_end,
    input  wire logic       srq_on,
    // Bus
    input  wire pins_t      bus,
    output pins_t           oe_n,
    // Observed
    output logic [7:0]      got,
    output logic            got_atn,
    output logic            got_eoi,
    output logic [7:0]      got_cnt,
    output logic            done
);
    // =========================================================
    // Handshake engine
    // =========================================================
    logic [1:0] st_r;   // Step of the cycle
    logic [3:0] cnt_r;  // Free delay counter, wraps within 16

    // Low enable pulls low; lines high once all release
    always @(posedge mclk)
    begin
        cnt_r <= cnt_r + 4'h1;
        if (!rstn || mode == 2'h0 || !bus.ctl_n.ifc)
        begin
            // Clear aborts the cycle and frees every line but service request, which follows srq_on
            oe_n  <= '1;
            st_r  <= 2'h0;
            cnt_r <= 4'h0;
            done  <= 1'b0;
            if (!rstn)
                got_cnt <= 8'h00;
        end
        else if (mode == 2'h1)
            case (st_r)
                2'h0:
                begin
                    oe_n.ctl_n.nrfd <= 1'b0; // Start state
                    oe_n.ctl_n.ndac <= 1'b0;
                    if (cnt_r == lat)
                    begin
                        oe_n.ctl_n.nrfd <= 1'b1; // Ready
                        st_r <= 2'h1;
                    end
                end
                2'h1:
                    if (!bus.ctl_n.dav)
                    begin
                        oe_n.ctl_n.nrfd <= 1'b0;
                        got     <= ~bus.data_n;
                        got_atn <= ~bus.ctl_n.atn; // Command flag
                        got_eoi <= ~bus.ctl_n.eoi;
                        cnt_r   <= 4'h0;
                        st_r    <= 2'h2;
                    end
                2'h2:
                    if (cnt_r == lat)
                    begin
                        oe_n.ctl_n.ndac <= 1'b1; // Accepted
                        got_cnt <= got_cnt + 8'h01;
                        st_r <= 2'h3;
                    end
                default:
                    if (bus.ctl_n.dav)
                    begin
                        oe_n.ctl_n.ndac <= 1'b0;
                        cnt_r <= 4'h0;
                        st_r  <= 2'h0;
                    end
            endcase
        else
            case (st_r)
                2'h0:
                    if (bus.ctl_n.nrfd)
                    begin
                        oe_n.data_n    <= ~tb_byte; // Byte after ready
                        oe_n.ctl_n.eoi <= ~tb_end;
                        cnt_r <= 4'h0;
                        st_r  <= 2'h1;
                    end
                2'h1:
                    if (cnt_r == lat)
                    begin
                        oe_n.ctl_n.dav <= 1'b0;
                        st_r <= 2'h2;
                    end
                2'h2:
                    if (bus.ctl_n.ndac)
                    begin
                        oe_n <= '1; // Valid and data drop together
                        done <= 1'b1;
                        st_r <= 2'h3;
                    end
                default: ;
            endcase
        // Held until the bench drops it
        oe_n.ctl_n.srq <= ~srq_on;
    end
endmodule

// ---- verification/ieee488_bus_handshake_test.sv ----
// Purpose: Self-checking bench for the bus controller.
// Assumes: Pull-ups on every line; one instrument on the bus.
// Notes:   Interface clear shortened to 10 cycles.
`timescale 1ns/1ps
module ieee488_bus_handshake_test;
    import bus488_pkg::*;

    // =========================================================
    // Signals
    // =========================================================
    logic mclk, rstn, tx_valid, tx_cmd, tx_last, tx_ready;
    logic rx_valid, rx_end, rx_cmd, rx_ready, talk_en, listen_en;
    logic ifc_req, ren_set, pass_ctl, take_ctl, srq_req;
    logic active_ctl, srq_seen, remote, ifc_busy;
    logic tb_end, srq_on, got_atn, got_eoi, done;
    logic [7:0] tx_byte, rx_byte, d_oe, tb_byte, got, got_cnt;
    logic [1:0] mode;
    logic [3:0] lat;
    lines_t     c_oe;
    pins_t      w, m_oe;   // Resolved wires and model enables
    int         err_total, n_checks;

    // Wired-AND of every driver stands in for the pull-ups
    assign w = {d_oe & m_oe.data_n, c_oe & m_oe.ctl_n};

    typedef struct packed {
        logic [7:0] b;
        logic       c, l;
        logic [3:0] lt;
        logic [7:0] eb;
        logic       ea, ee;
    } row_t;
    // Byte, command, last, delay; then byte, attention, end seen
    localparam row_t ROWS [5] = '{
        '{8'hA5, 1'b0, 1'b0, 4'h0, 8'hA5, 1'b0, 1'b0},
        '{8'hC1, 1'b1, 1'b0, 4'h2, 8'h41, 1'b1, 1'b0},
        '{8'h3C, 1'b0, 1'b1, 4'hF, 8'h3C, 1'b0, 1'b1},
        '{8'hFF, 1'b0, 1'b0, 4'h3, 8'hFF, 1'b0, 1'b0},
        '{8'h00, 1'b0, 1'b1, 4'h0, 8'h00, 1'b0, 1'b1}};

    bus488_ctrl #(.IFC_CYCLES(10), .SYS_CTRL(1'b1)) bus488_ctrl_i (
        .mclk, .rstn, .pin_in(w), .data_oe_n(d_oe), .ctl_oe_n(c_oe), .tx_valid,
        .tx_byte, .tx_cmd, .tx_last, .tx_ready, .rx_valid, .rx_byte, .rx_end,
        .rx_cmd, .rx_ready, .talk_en, .listen_en, .ifc_req, .ren_set, .pass_ctl,
        .take_ctl, .srq_req, .active_ctl, .srq_seen, .remote, .ifc_busy);

    instr_model instr_model_i (
        .mclk, .rstn, .mode, .lat, .tb_byte, .tb_end, .srq_on, .bus(w),
        .oe_n(m_oe), .got, .got_atn, .got_eoi, .got_cnt, .done);

    // =========================================================
    // Helpers
    // =========================================================
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Compare and count; unknowns never match
    task automatic chk(input string what, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Step n edges, then drive just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Wait on a flag at the falling edge, bounded
    task automatic wait_hi(ref logic f);
        int k;
        k = 0;
        while (f !== 1'b1 && k < 3000)
        begin
            @(negedge mclk);
            k++;
        end
        chk("wait", 8'(k < 3000), 8'h01);
    endtask

    // One byte; valid stays up so rows run back to back
    task automatic send(input logic [7:0] b, input logic c, l);
        tx_byte  = b;
        tx_cmd   = c;
        tx_last  = l;
        tx_valid = 1'b1;
        @(negedge mclk);
        wait_hi(tx_ready);
        tick(1);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog far past the run length
    initial
    begin
        #(8 * 20000);
        err_total++;
        conclude();
    end

    // =========================================================
    // Tests
    // =========================================================
    initial
    begin
        {tx_valid, tx_cmd, tx_last, rx_ready, talk_en, listen_en} = '0;
        {ifc_req, ren_set, pass_ctl, take_ctl, srq_req, srq_on} = '0;
        {tx_byte, tb_byte, tb_end, mode, lat} = '0;
        err_total = 0;
        n_checks = 0;
        rstn = 1'b0;
        tick(10);
        chk("width", 8'($bits(pins_t)), 8'h10);
        chk("data_oe", d_oe, 8'hFF);
        chk("ctl_oe", c_oe, 8'hFF);
        chk("active", active_ctl, 1'b1);
        chk("tx_ready", tx_ready, 1'b0);
        rstn = 1'b1;
        $display("test reset done");
        // Talk rows against a listener of varying speed
        mode = 2'h1;
        talk_en = 1'b1;
        tick(3);
        for (int i = 0; i < 5; i++)
        begin
            lat = ROWS[i].lt;
            send(ROWS[i].b, ROWS[i].c, ROWS[i].l);
            chk("byte", got, ROWS[i].eb);
            chk("atn", got_atn, ROWS[i].ea);
            chk("eoi", got_eoi, ROWS[i].ee);
            chk("data_free", w.data_n, 8'hFF);
            chk("dav_free", w.ctl_n.dav, 1'b1);
        end
        tx_valid = 1'b0;
        chk("count", got_cnt, 8'h05);
        $display("test talk done");
        // No talking without authorization
        tick(1);
        talk_en = 1'b0;
        tx_valid = 1'b1;
        tick(200);
        chk("refused", got_cnt, 8'h05);
        tx_valid = 1'b0;
        $display("test refuse done");
        // Listen to one byte from the instrument
        mode = 2'h0;
        listen_en = 1'b1;
        tick(10);
        tb_byte = 8'h5A;
        tb_end = 1'b1;
        mode = 2'h2;
        wait_hi(rx_valid);
        chk("rx_byte", rx_byte, 8'h5A);
        chk("rx_end", rx_end, 1'b1);
        chk("rx_cmd", rx_cmd, 1'b0);
        tick(1);
        rx_ready = 1'b1;
        tick(1);
        rx_ready = 1'b0;
        tick(40);
        chk("talk_done", done, 1'b1);
        mode = 2'h0;
        $display("test listen done");
        // Remote, control passing, then interface clear
        ren_set = 1'b1;
        tick(10);
        chk("remote", remote, 1'b1);
        listen_en = 1'b0;
        tick(1);
        pass_ctl = 1'b1;
        tick(1);
        pass_ctl = 1'b0;
        tick(3);
        chk("passed", active_ctl, 1'b0);
        take_ctl = 1'b1;
        tick(1);
        take_ctl = 1'b0;
        tick(3);
        chk("taken", active_ctl, 1'b1);
        pass_ctl = 1'b1;
        tick(1);
        pass_ctl = 1'b0;
        tick(3);
        ifc_req = 1'b1;
        tick(1);
        ifc_req = 1'b0;
        tick(4);
        chk("ifc_line", w.ctl_n.ifc, 1'b0);
        chk("ifc_busy", ifc_busy, 1'b1);
        tick(30);
        chk("regain", active_ctl, 1'b1);
        chk("unremote", remote, 1'b0);
        $display("test control done");
        // Service request both ways
        srq_on = 1'b1;
        tick(5);
        chk("srq_seen", srq_seen, 1'b1);
        srq_on = 1'b0;
        srq_req = 1'b1;
        tick(5);
        chk("srq_line", w.ctl_n.srq, 1'b0);
        $display("test service done");
        conclude();
    end
endmodule
